// ===== hw/timeout_decode.sv
// decodes a four-bit timeout code into watchdog oscillator cycles
`timescale 1ns/1ps
`default_nettype none
module timeout_decode
  import wdt_pkg::*;
(
  timeout_if.dec tmo
);

  always_comb begin
    if (tmo.code == CODE_OFF) begin
      tmo.cycles = '0;
    end else if (tmo.code <= CODE_MAX) begin
      tmo.cycles = CNT_W'(BASE_CYCLES << (tmo.code - 4'h1));
    end else begin
      // reserved codes fall back to the longest period rather than disabling
      tmo.cycles = MAX_CYCLES;
    end
  end

endmodule // timeout_decode
`default_nettype wire

// ===== hw/timeout_if.sv
// timeout code to cycle count link between the core and its decoders
`timescale 1ns/1ps
`default_nettype none
interface timeout_if;
  import wdt_pkg::*;
  logic [CODE_W-1:0] code;
  logic [CNT_W-1:0] cycles;
  modport dec (input code, output cycles);
  modport user (output code, input cycles);
endinterface
`default_nettype wire

// ===== hw/wdt_pkg.sv
// constants and types shared by the windowed watchdog timer
package wdt_pkg;

  localparam int unsigned CODE_W = 4;
  localparam int unsigned CNT_W = 14;
  localparam int unsigned CTRL_W = 8;

  // control register field positions
  localparam int unsigned PERIOD_LSB = 0;
  localparam int unsigned WINDOW_LSB = 4;

  // value after reset, before the fuse image is loaded
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic LOCK_RESET = 1'b0;

  // timeout codes: code 1 is the base period, each further code doubles it
  localparam logic [CODE_W-1:0] CODE_OFF = 4'h0;
  localparam logic [CODE_W-1:0] CODE_MAX = 4'hB;
  localparam int unsigned OSC_RATE_HZ = 1000;
  localparam int unsigned BASE_TIMEOUT_MS = 8;
  localparam int unsigned BASE_TICKS = (BASE_TIMEOUT_MS * OSC_RATE_HZ) / 1000;
  localparam logic [CNT_W-1:0] BASE_CYCLES = CNT_W'(BASE_TICKS);
  localparam logic [CNT_W-1:0] MAX_CYCLES = CNT_W'(BASE_TICKS << (CODE_MAX - 4'h1));

  // crossing into the oscillator domain: the third oscillator edge applies the value
  localparam logic [1:0] SYNC_LAST_TICK = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_NORMAL = 3'b001,
    ST_ARMED  = 3'b010,
    ST_CLOSED = 3'b011,
    ST_OPEN   = 3'b100,
    ST_HALT   = 3'b101
  } wdt_state_t;

endpackage

// ===== hw/windowed_watchdog_timer.sv
// windowed watchdog timer with protected control, lock and debug handling
// Behaviour
// - enabled watchdog issues system reset when no clear arrives before timeout.
// - counter advances on edges of the independent 1 kHz watchdog oscillator.
// - eleven timeout lengths, 8 ms to 8 s, picked by the period field.
// - non-zero period field enables the watchdog, zero disables it.
// - each accepted clear restarts the counter with a fresh period.
// - window field zero gives normal mode, one period, no closed interval.
// - non-zero window field turns window mode on, zero turns it off.
// - clear during the closed interval causes a system reset.
// - open interval follows the closed one; total timeout is their sum.
// - after enabling window mode or leaving debug, first clear starts closed.
// - counting continues in any power mode only while the system clock runs; the oscillator is sampled on clk_in.
// - debug halt stops counting and clears the counter.
// - leaving debug in window mode runs one normal period first.
// - control and lock writes only count during the protection unlock window.
// - control writes are ignored while the lock bit is set.
// - lock accepts only writes of one; only debug mode clears it.
// - control loads from fuses at boot; enabled fuse image sets lock.
// - control writes reach the counter only after crossing to the oscillator.
// - pending flag is high while a control write crosses domains.
// - clear takes two to three oscillator cycles; clears meanwhile are ignored.
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer
  import wdt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic watchdog_osc_clock_in,
  input wire logic [CTRL_W-1:0] watchdog_fuse_config_in,
  input wire logic config_change_protection_in,
  input wire logic ctrl_wr_in,
  input wire logic [CTRL_W-1:0] ctrl_wdata_in,
  input wire logic lock_wr_in,
  input wire logic lock_wdata_in,
  input wire logic watchdog_clear_instruction_in,
  input wire logic debug_halt_in,
  input wire logic debug_lock_clear_in,
  output logic [CTRL_W-1:0] watchdog_control_reg_out,
  output logic lock_out,
  output logic sync_pending_flag_out,
  output logic clear_pending_out,
  output logic [2:0] wdt_state_out,
  output logic system_reset_out
);

  typedef struct packed {
    logic boot;
    logic osc_prev;
    logic [CTRL_W-1:0] ctrl;
    logic [CTRL_W-1:0] eff;
    logic lock;
    logic ctrl_pend;
    logic [1:0] ctrl_ticks;
    logic clr_pend;
    logic [1:0] clr_ticks;
    wdt_state_t st;
    logic [CNT_W-1:0] cnt;
    logic sys_rst;
  } wdt_regs_t;

  wdt_regs_t state_ff;
  wdt_regs_t nxt_state;

  timeout_if per_if ();
  timeout_if win_if ();

  timeout_decode u_per_decode (
    .tmo (per_if.dec)
  );

  timeout_decode u_win_decode (
    .tmo (win_if.dec)
  );

  logic osc_tick;
  logic [CODE_W-1:0] eff_period;
  logic [CODE_W-1:0] eff_window;
  logic per_on;
  logic win_on;
  logic fuse_enabled;
  logic ctrl_accept;
  logic lock_accept;
  logic ctrl_apply;
  logic clr_fire;
  logic clr_start;
  wdt_state_t mode_st;
  logic [CNT_W-1:0] limit;
  logic cnt_last;
  logic in_closed;
  logic [CNT_W-1:0] last_count;
  wdt_state_t resume_st;
  wdt_state_t clr_st;
  logic clr_fatal;

  // the oscillator is sampled as a plain synchronous input, so the system
  // clock must run well above it; the counter only advances on system clock edges
  // limitation: with the system clock stopped no reset can be raised
  assign osc_tick = watchdog_osc_clock_in & ~state_ff.osc_prev;

  assign eff_period = state_ff.eff[PERIOD_LSB +: CODE_W];
  assign eff_window = state_ff.eff[WINDOW_LSB +: CODE_W];
  assign per_on = (eff_period != CODE_OFF);
  assign win_on = (eff_window != CODE_OFF);
  assign fuse_enabled = (watchdog_fuse_config_in[PERIOD_LSB +: CODE_W] != CODE_OFF);

  // the decoders see the applied copy, never a write still crossing
  assign per_if.code = eff_period;
  assign win_if.code = eff_window;

  // a write outside the unlock window is simply dropped
  assign ctrl_accept = ~state_ff.boot & ctrl_wr_in & config_change_protection_in
                       & ~state_ff.lock & ~state_ff.ctrl_pend;
  assign lock_accept = ~state_ff.boot & lock_wr_in & config_change_protection_in
                       & lock_wdata_in;

  assign ctrl_apply = state_ff.ctrl_pend & osc_tick
                      & (state_ff.ctrl_ticks == SYNC_LAST_TICK);
  assign clr_fire = state_ff.clr_pend & osc_tick
                    & (state_ff.clr_ticks == SYNC_LAST_TICK);

  // a clear landing in the cycle its predecessor completes starts a new crossing
  assign clr_start = watchdog_clear_instruction_in & ~debug_halt_in
                     & (~state_ff.clr_pend | clr_fire);

  // follow a live change of the window field without disturbing the count
  always_comb begin
    mode_st = state_ff.st;
    unique case (state_ff.st)
      ST_NORMAL: begin
        if (win_on) begin
          mode_st = ST_ARMED;
        end
      end
      ST_ARMED, ST_CLOSED, ST_OPEN: begin
        if (!win_on) begin
          mode_st = ST_NORMAL;
        end
      end
      ST_OFF, ST_HALT: begin
        mode_st = state_ff.st;
      end
      default: begin
        mode_st = ST_OFF;
      end
    endcase
  end

  assign in_closed = (mode_st == ST_CLOSED);
  assign limit = in_closed ? win_if.cycles : per_if.cycles;
  assign last_count = CNT_W'(limit - CNT_W'(1));
  // a live change to a shorter period must still expire, not wait for a wrap
  assign cnt_last = (state_ff.cnt >= last_count);

  // where counting starts from idle or after debug; window mode waits for a clear
  // a zero period keeps the watchdog idle whatever the window field holds
  always_comb begin
    if (!per_on) begin
      resume_st = ST_OFF;
    end else if (win_on) begin
      resume_st = ST_ARMED;
    end else begin
      resume_st = ST_NORMAL;
    end
  end

  // what a clear that has finished crossing does in each mode
  // a clear in the closed interval is fatal and leaves the counter idle
  always_comb begin
    clr_st = ST_OFF;
    clr_fatal = 1'b0;
    unique case (mode_st)
      ST_NORMAL: begin
        clr_st = ST_NORMAL;
      end
      ST_ARMED, ST_OPEN: begin
        clr_st = ST_CLOSED;
      end
      ST_CLOSED: begin
        clr_fatal = 1'b1;
        clr_st = ST_OFF;
      end
      default: begin
        clr_st = ST_OFF;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.osc_prev = watchdog_osc_clock_in;
    nxt_state.sys_rst = 1'b0;

    if (state_ff.boot) begin
      // fuse image is caught on the first edge after reset release
      nxt_state.boot = 1'b0;
      nxt_state.ctrl = watchdog_fuse_config_in;
      nxt_state.eff = watchdog_fuse_config_in;
      nxt_state.lock = fuse_enabled;
    end else begin
      // control register write and its crossing
      if (ctrl_accept) begin
        nxt_state.ctrl = ctrl_wdata_in;
        nxt_state.ctrl_pend = 1'b1;
        nxt_state.ctrl_ticks = 2'h0;
      end else if (ctrl_apply) begin
        nxt_state.eff = state_ff.ctrl;
        nxt_state.ctrl_pend = 1'b0;
        nxt_state.ctrl_ticks = 2'h0;
      end else if (state_ff.ctrl_pend && osc_tick) begin
        nxt_state.ctrl_ticks = state_ff.ctrl_ticks + 2'h1;
      end

      // lock: software may only set it; a set in the same cycle beats a clear
      if (lock_accept) begin
        nxt_state.lock = 1'b1;
      end else if (debug_halt_in && debug_lock_clear_in) begin
        nxt_state.lock = 1'b0;
      end

      // clear instruction crossing
      if (clr_start) begin
        nxt_state.clr_pend = 1'b1;
        nxt_state.clr_ticks = 2'h0;
      end else if (clr_fire) begin
        nxt_state.clr_pend = 1'b0;
        nxt_state.clr_ticks = 2'h0;
      end else if (state_ff.clr_pend && osc_tick) begin
        nxt_state.clr_ticks = state_ff.clr_ticks + 2'h1;
      end

      // counter and mode sequencing
      if (debug_halt_in) begin
        nxt_state.st = ST_HALT;
        nxt_state.cnt = '0;
        nxt_state.clr_pend = 1'b0;
        nxt_state.clr_ticks = 2'h0;
      end else if (state_ff.st == ST_HALT) begin
        nxt_state.cnt = '0;
        // armed runs a plain period; the first clear opens the closed interval
        nxt_state.st = resume_st;
      end else if (!per_on) begin
        nxt_state.st = ST_OFF;
        nxt_state.cnt = '0;
      end else if (state_ff.st == ST_OFF) begin
        nxt_state.cnt = '0;
        nxt_state.st = resume_st;
      end else if (clr_fire) begin
        nxt_state.cnt = '0;
        nxt_state.st = clr_st;
        nxt_state.sys_rst = clr_fatal;
      end else if (osc_tick) begin
        if (cnt_last) begin
          nxt_state.cnt = '0;
          if (in_closed) begin
            nxt_state.st = ST_OPEN;
          end else begin
            nxt_state.sys_rst = 1'b1;
            nxt_state.st = ST_OFF;
          end
        end else begin
          nxt_state.cnt = state_ff.cnt + CNT_W'(1);
          nxt_state.st = mode_st;
        end
      end else begin
        nxt_state.st = mode_st;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff.boot <= 1'b1;
      state_ff.osc_prev <= 1'b0;
      state_ff.ctrl <= CTRL_RESET;
      state_ff.eff <= CTRL_RESET;
      state_ff.lock <= LOCK_RESET;
      state_ff.ctrl_pend <= 1'b0;
      state_ff.ctrl_ticks <= 2'h0;
      state_ff.clr_pend <= 1'b0;
      state_ff.clr_ticks <= 2'h0;
      state_ff.st <= ST_OFF;
      state_ff.cnt <= '0;
      state_ff.sys_rst <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign watchdog_control_reg_out = state_ff.ctrl;
  assign lock_out = state_ff.lock;
  assign sync_pending_flag_out = state_ff.ctrl_pend;
  assign clear_pending_out = state_ff.clr_pend;
  assign wdt_state_out = state_ff.st;
  assign system_reset_out = state_ff.sys_rst;

endmodule // windowed_watchdog_timer
`default_nettype wire

// ===== tb/core_model.sv
// processor core model: protected writes and clear instructions
`timescale 1ns/1ps
`default_nettype none
module core_model
  import wdt_pkg::*;
(
  input wire logic clk_in,
  input wire logic sync_pending_in,
  output logic unlock_out,
  output logic ctrl_wr_out,
  output logic [CTRL_W-1:0] ctrl_wdata_out,
  output logic lock_wr_out,
  output logic lock_wdata_out,
  output logic clear_out
);
  initial begin
    {unlock_out, ctrl_wr_out, lock_wr_out, lock_wdata_out, clear_out} = 5'h00;
    ctrl_wdata_out = 8'h00;
  end
  // key first, protected store on the next instruction, well inside four
  task automatic pwrite(input logic ctl, input logic [CTRL_W-1:0] d, input logic key);
    int n;
    n = 0;
    while (sync_pending_in && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    if (sync_pending_in) begin
      tb_top.errors++;
      $display("ERROR %0t: pending flag never dropped", $time);
      tb_top.end_of_test();
    end
    @(negedge clk_in);
    unlock_out = key;
    @(negedge clk_in);
    ctrl_wr_out = ctl;
    lock_wr_out = !ctl;
    ctrl_wdata_out = d;
    lock_wdata_out = d[0];
    @(negedge clk_in);
    {unlock_out, ctrl_wr_out, lock_wr_out} = 3'h0;
    // released data must not look valid
    ctrl_wdata_out = ~d;
    lock_wdata_out = ~d[0];
  endtask
  task automatic watchdog_clear_instruction();
    @(negedge clk_in);
    clear_out = 1'h1;
    @(negedge clk_in);
    clear_out = 1'h0;
  endtask
endmodule // core_model
`default_nettype wire

// ===== tb/tb_top.sv
// testbench: boot, timeouts, window mode, debug and lock
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import wdt_pkg::*;
;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic watchdog_osc_clock_in = 1'h0;
  logic debug_halt_in = 1'h0;
  logic debug_lock_clear_in = 1'h0;
  logic [CTRL_W-1:0] watchdog_fuse_config_in = 8'h01;
  logic config_change_protection_in, ctrl_wr_in, lock_wr_in, lock_wdata_in;
  logic [CTRL_W-1:0] ctrl_wdata_in, watchdog_control_reg_out;
  logic watchdog_clear_instruction_in, lock_out, sync_pending_flag_out;
  logic clear_pending_out, system_reset_out;
  logic [2:0] wdt_state_out;
  int errors = 0, check_count = 0, n, pulses = 0, p;
  always #50 clk_in = ~clk_in;
  // osc much faster than 1 kHz to keep the run short; tick every 8 clocks
  always #400 watchdog_osc_clock_in = ~watchdog_osc_clock_in;
  always @(posedge clk_in) if (system_reset_out === 1'h1) pulses++;
  windowed_watchdog_timer u_dut (.clk_in, .rst_in, .watchdog_osc_clock_in,
    .watchdog_fuse_config_in, .config_change_protection_in, .ctrl_wr_in, .ctrl_wdata_in,
    .lock_wr_in, .lock_wdata_in, .watchdog_clear_instruction_in, .debug_halt_in,
    .debug_lock_clear_in, .watchdog_control_reg_out, .lock_out, .sync_pending_flag_out,
    .clear_pending_out, .wdt_state_out, .system_reset_out);
  core_model u_core (.clk_in, .sync_pending_in(sync_pending_flag_out),
    .unlock_out(config_change_protection_in), .ctrl_wr_out(ctrl_wr_in),
    .ctrl_wdata_out(ctrl_wdata_in), .lock_wr_out(lock_wr_in), .lock_wdata_out(lock_wdata_in),
    .clear_out(watchdog_clear_instruction_in));
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // waits end on state or reset pulse, never open-ended
  task automatic wait_for(input logic rst, input logic [2:0] s, input int lim);
    n = 0;
    while ((rst ? system_reset_out !== 1'h1 : wdt_state_out !== s) && n < lim) begin
      @(negedge clk_in);
      n++;
    end
    check_count++;
    if (n >= lim) begin
      errors++;
      $display("ERROR %0t: wait timed out", $time);
      end_of_test();
    end
  endtask
  initial begin
    repeat (8) @(negedge clk_in);
    rst_in = 1'h0;
    repeat (2) @(negedge clk_in);
    chk(watchdog_control_reg_out, 8'h01);
    chk(lock_out, 1'h1);
    chk(wdt_state_out, 3'h1);
    u_core.pwrite(1'h1, 8'h02, 1'h1);
    chk(watchdog_control_reg_out, 8'h01);
    wait_for(1'h1, 3'h0, 120);
    chk(n >= 40 && n <= 80, 1'h1);
    $display("test boot_timeout done");
    debug_halt_in = 1'h1;
    debug_lock_clear_in = 1'h1;
    repeat (3) @(negedge clk_in);
    chk(wdt_state_out, 3'h5);
    chk(lock_out, 1'h0);
    debug_halt_in = 1'h0;
    debug_lock_clear_in = 1'h0;
    wait_for(1'h0, 3'h1, 4);
    u_core.pwrite(1'h1, 8'h21, 1'h0);
    chk(watchdog_control_reg_out, 8'h01);
    u_core.pwrite(1'h1, 8'h21, 1'h1);
    chk(watchdog_control_reg_out, 8'h21);
    chk(sync_pending_flag_out, 1'h1);
    wait_for(1'h0, 3'h2, 60);
    u_core.watchdog_clear_instruction();
    chk(clear_pending_out, 1'h1);
    wait_for(1'h0, 3'h3, 40);
    wait_for(1'h0, 3'h4, 160);
    chk(n >= 112, 1'h1);
    u_core.watchdog_clear_instruction();
    wait_for(1'h0, 3'h3, 40);
    repeat (20) @(negedge clk_in);
    u_core.watchdog_clear_instruction();
    wait_for(1'h1, 3'h0, 40);
    $display("test window done");
    debug_halt_in = 1'h1;
    repeat (3) @(negedge clk_in);
    chk(wdt_state_out, 3'h5);
    debug_halt_in = 1'h0;
    wait_for(1'h0, 3'h2, 4);
    wait_for(1'h1, 3'h0, 120);
    chk(n >= 56 && n <= 72, 1'h1);
    $display("test debug_window done");
    u_core.pwrite(1'h1, 8'h00, 1'h1);
    wait_for(1'h0, 3'h0, 60);
    u_core.pwrite(1'h1, 8'h01, 1'h1);
    wait_for(1'h0, 3'h1, 60);
    p = pulses;
    repeat (6) begin
      repeat (28) @(negedge clk_in);
      u_core.watchdog_clear_instruction();
    end
    chk(8'(pulses - p), 8'h00);
    $display("test normal_clear done");
    u_core.pwrite(1'h0, 8'h01, 1'h1);
    chk(lock_out, 1'h1);
    debug_halt_in = 1'h1;
    repeat (3) @(negedge clk_in);
    chk(lock_out, 1'h1);
    debug_halt_in = 1'h0;
    u_core.pwrite(1'h1, 8'h00, 1'h1);
    chk(watchdog_control_reg_out, 8'h01);
    $display("test lock done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire

// ===== tb/wdt_checker.sv
// assertions on the watchdog timer ports
`timescale 1ns/1ps
`default_nettype none
module wdt_checker
  import wdt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic watchdog_osc_clock_in,
  input wire logic config_change_protection_in,
  input wire logic ctrl_wr_in,
  input wire logic [CTRL_W-1:0] ctrl_wdata_in,
  input wire logic watchdog_clear_instruction_in,
  input wire logic debug_halt_in,
  input wire logic debug_lock_clear_in,
  input wire logic [CTRL_W-1:0] watchdog_control_reg_out,
  input wire logic lock_out,
  input wire logic sync_pending_flag_out,
  input wire logic clear_pending_out,
  input wire logic [2:0] wdt_state_out,
  input wire logic system_reset_out
);
  logic seen_ff, osc_ff, tick;
  logic [1:0] sync_tk_ff, clr_tk_ff;
  // boot edge excluded: fuse image loads there and strobes are ignored
  assign tick = watchdog_osc_clock_in & ~osc_ff;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      seen_ff <= 1'h0;
      osc_ff <= 1'h0;
      sync_tk_ff <= 2'h0;
      clr_tk_ff <= 2'h0;
    end else begin
      seen_ff <= 1'h1;
      osc_ff <= watchdog_osc_clock_in;
      sync_tk_ff <= sync_pending_flag_out ? sync_tk_ff + 2'(tick) : 2'h0;
      // a finished crossing restarts its count even when a new clear follows at once
      clr_tk_ff <= (clear_pending_out && !(tick && clr_tk_ff == 2'h2))
        ? clr_tk_ff + 2'(tick) : 2'h0;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  single_pulse_a: assert property (system_reset_out |=> !system_reset_out)
    else $error("reset pulse too wide");
  idle_after_a: assert property (system_reset_out |-> ##[0:1] wdt_state_out == 3'h0)
    else $error("counter not idle after reset pulse");
  lock_hold_a: assert property ($fell(lock_out) |-> $past(debug_halt_in) && $past(debug_lock_clear_in))
    else $error("lock cleared outside debug");
  ctrl_frozen_a: assert property (lock_out |=> $stable(watchdog_control_reg_out))
    else $error("control changed while locked");
  ctrl_take_a: assert property (seen_ff && ctrl_wr_in && config_change_protection_in && !lock_out
    && !sync_pending_flag_out |=> watchdog_control_reg_out == $past(ctrl_wdata_in) && sync_pending_flag_out)
    else $error("protected write not taken");
  no_unlock_a: assert property (seen_ff && !(ctrl_wr_in && config_change_protection_in)
    |=> $stable(watchdog_control_reg_out))
    else $error("control changed without unlocked write");
  sync_done_a: assert property (sync_pending_flag_out && tick && sync_tk_ff == 2'h2
    |-> ##[1:2] !sync_pending_flag_out)
    else $error("pending flag outlives third tick");
  clr_take_a: assert property (seen_ff && watchdog_clear_instruction_in && !debug_halt_in
    && !clear_pending_out |=> clear_pending_out)
    else $error("clear not taken");
  clr_done_a: assert property (clear_pending_out && tick && clr_tk_ff == 2'h2
    && !(watchdog_clear_instruction_in && !debug_halt_in) |-> ##[1:2] !clear_pending_out)
    else $error("clear crossing too long");
  clr_again_a: assert property (clear_pending_out && tick && clr_tk_ff == 2'h2
    && watchdog_clear_instruction_in && !debug_halt_in |=> clear_pending_out)
    else $error("clear at crossing end not taken");
  halt_a: assert property (seen_ff && debug_halt_in |=> wdt_state_out == 3'h5)
    else $error("no halt in debug");
endmodule // wdt_checker
bind windowed_watchdog_timer wdt_checker u_chk (.clk_in, .rst_in, .watchdog_osc_clock_in,
  .config_change_protection_in, .ctrl_wr_in, .ctrl_wdata_in, .watchdog_clear_instruction_in,
  .debug_halt_in, .debug_lock_clear_in, .watchdog_control_reg_out, .lock_out,
  .sync_pending_flag_out, .clear_pending_out, .wdt_state_out, .system_reset_out);
`default_nettype wire
